/* File: src/calendar_clock_unit.sv */
// Calendar clock unit: Wishbone register front end, timebase, alarm.
// Assumes a classic Wishbone master and free-running timebase pins.
//
// Operation
// (RULE1) Source select 00 crystal, 01 RC, 10 line 50 Hz, 11 line 60 Hz.
// (RULE2) Reference is 32.768 kHz crystal, 31.25 kHz RC, or 50/60 Hz line.
// (RULE3) Time pointer selects min/sec, weekday/hours, month/day, year.
// (RULE4) High byte write of time window decrements pointer, stops at 00.
// (RULE5) Any read of the time window decrements its pointer.
// (RULE6) Alarm pointer selects alarm min/sec, weekday/hours, month/day, none.
// (RULE7) High byte write of alarm window decrements pointer, stops at 00.
// (RULE8) Any read of the alarm window decrements its pointer.
// (RULE9) Time value writes are ignored unless the write unlock bit is set.
// (RULE10) Unlock bit sets only right after the 55h, AAh key sequence.
// (RULE11) Module-on bit is writable only while unlocked.
// (RULE12) Bit 15 switches the unit on; config resets to zero.
// (RULE13) Ripple flag is set while a rollover may corrupt a read.
// (RULE14) Half-second bit shows second half; low min/sec write clears it.
// (RULE15) Bit 10 enables the unit output.
// (RULE16) Config register is cleared only by power-on reset.
// (RULE17) Drift trim is applied once every 15 seconds.
// (RULE18) 24-hour BCD calendar with leap years for 2000 to 2099.
// (RULE19) Alarm masks from half second to year, repeat count and chime; the code's masks stop at month (mask 9).
// (RULE20) Trim is a signed 8-bit pulse count, zero means none.
// (RULE21) One-second tick carries through the calendar with BCD rollover.
`timescale 1ns/1ps
module calendar_clock_unit
   import calclk_pkg::*;
(
   input wire logic clk,           // 20 MHz system clock
   input wire logic resetn,        // Power-on reset, active low
   input wire logic sys_rst,       // Other reset, synchronous, active high
   input wire logic wb_cyc_i,      // Wishbone cycle
   input wire logic wb_stb_i,      // Wishbone strobe
   input wire logic wb_we_i,       // Wishbone write
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte enables
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o,   // Wishbone read data
   output logic wb_ack_o,          // Wishbone acknowledge
   input wire logic secondary_crystal_osc_in,       // Secondary crystal timebase pin
   input wire logic low_power_rc_osc_in,       // Low-power RC timebase
   input wire logic line_in,       // Power-line timebase pin
   output logic unit_out,          // Seconds square wave output
   output logic alarm_pulse        // One-cycle alarm event
);
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_type;

   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
      logic [15:0] cfg;
      logic [15:0] acfg;
      logic [1:0] src;
      logic [15:0] a_ms;
      logic [15:0] a_wh;
      logic [15:0] a_md;
      key_type key;
      logic [2:0] kcnt;
      logic signed [17:0] presc;
      logic [3:0] trim;
      logic half;
      logic tick_d;
      logic half_d;
      logic alarm;
      logic out;
   } st_type;

   st_type s_r;
   st_type s_nxt;
   logic rst_meta_r;
   logic rst_n;
   logic secondary_crystal_osc_rise;
   logic low_power_rc_osc_rise;
   logic line_rise;
   logic acc;
   logic wr;
   logic rd;
   logic unlock;
   logic ripple;
   logic tick;
   logic hit;
   logic [1:0] ptr;
   logic [1:0] aptr;
   logic [15:0] dat;
   logic signed [17:0] lim;
   cal_if ci ();

   // =======================================================
   // Reset release and submodules
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   pulse_sync u_secondary_crystal_osc (.clk(clk), .rst_n(rst_n), .din(secondary_crystal_osc_in),
                      .rise(secondary_crystal_osc_rise));
   pulse_sync u_low_power_rc_osc (.clk(clk), .rst_n(rst_n), .din(low_power_rc_osc_in),
                      .rise(low_power_rc_osc_rise));
   pulse_sync u_line (.clk(clk), .rst_n(rst_n), .din(line_in),
                      .rise(line_rise));
   calendar_count u_cal (.clk(clk), .rst_n(rst_n), .ci(ci.cnt));

   // =======================================================
   // Next state
   always_comb
   begin
      logic pulse;
      logic halfevt;
      time_type t;
      logic cs;
      logic cm;
      logic ch;
      logic cd;
      pulse = 1'b0;
      halfevt = 1'b0;
      t = ci.now;
      s_nxt = s_r;
      dat = wb_dat_i[15:0];
      acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = acc & wb_we_i;
      rd = acc & ~wb_we_i;
      unlock = s_r.cfg[UNLOCK_BIT];
      ptr = s_r.cfg[PTR_LSB+1:PTR_LSB];
      aptr = s_r.acfg[PTR_LSB+1:PTR_LSB];
      s_nxt.ack = acc;
      tick = 1'b0;
      case (s_r.src) // RULE1 RULE2
         2'h0:
         begin
            lim = 18'(SECONDARY_CRYSTAL_OSC_HZ);
            pulse = secondary_crystal_osc_rise;
         end
         2'h1:
         begin
            lim = 18'(LOW_POWER_RC_OSC_HZ);
            pulse = low_power_rc_osc_rise;
         end
         2'h2:
         begin
            lim = 18'(LINE50_HZ);
            pulse = line_rise;
         end
         default:
         begin
            lim = 18'(LINE60_HZ);
            pulse = line_rise;
         end
      endcase
      ripple = s_r.cfg[ON_BIT] && (s_r.presc >= lim - RIPPLE_PULSES); // RULE13

      // Prescaler, trim and half-second phase
      if (s_r.cfg[ON_BIT] && pulse) // RULE12
      begin
         if (s_r.presc + 18'sd1 >= lim)
         begin
            tick = 1'b1;
            s_nxt.trim = (s_r.trim == TRIM_SECONDS - 4'h1) ? 4'h0
                                                          : s_r.trim + 4'h1;
            s_nxt.presc = (s_r.trim == TRIM_SECONDS - 4'h1) // RULE17
                          ? 18'($signed(s_r.cfg[7:0])) : 18'sd0; // RULE20
         end
         else
            s_nxt.presc = s_r.presc + 18'sd1;
         s_nxt.half = s_nxt.presc >= (lim >>> 1); // RULE14
         halfevt = s_nxt.half & ~s_r.half;
      end
      s_nxt.tick_d = tick;
      s_nxt.half_d = halfevt;

      // Alarm match against the freshly updated time
      cs = t.sec == s_r.a_ms[7:0];
      cm = t.min == s_r.a_ms[15:8];
      ch = t.hr == s_r.a_wh[7:0];
      cd = t.day == s_r.a_md[7:0];
      case (s_r.acfg[MASK_LSB+3:MASK_LSB]) // RULE19
         4'h0: hit = s_r.half_d | s_r.tick_d;
         4'h1: hit = s_r.tick_d;
         4'h2: hit = s_r.tick_d & (t.sec[3:0] == s_r.a_ms[3:0]);
         4'h3: hit = s_r.tick_d & cs;
         4'h4: hit = s_r.tick_d & cs & (t.min[3:0] == s_r.a_ms[11:8]);
         4'h5: hit = s_r.tick_d & cs & cm;
         4'h6: hit = s_r.tick_d & cs & cm & ch;
         4'h7: hit = s_r.tick_d & cs & cm & ch & (t.wday == s_r.a_wh[15:8]);
         4'h8: hit = s_r.tick_d & cs & cm & ch & cd;
         4'h9: hit = s_r.tick_d & cs & cm & ch & cd &
                     (t.mon == s_r.a_md[15:8]);
         default: hit = 1'b0;
      endcase
      s_nxt.alarm = s_r.acfg[ALM_EN_BIT] & hit;
      if (s_r.acfg[ALM_EN_BIT] && hit) // RULE19
      begin
         if (s_r.acfg[7:0] == 8'h00 && !s_r.acfg[CHIME_BIT])
            s_nxt.acfg[ALM_EN_BIT] = 1'b0;
         else if (s_r.acfg[7:0] != 8'h00 || s_r.acfg[CHIME_BIT])
            s_nxt.acfg[7:0] = s_r.acfg[7:0] - 8'h01;
      end

      // Key sequence window
      if (s_r.key == KEY_OPEN)
      begin
         s_nxt.kcnt = s_r.kcnt - 3'h1;
         if (s_r.kcnt == 3'h1)
            s_nxt.key = KEY_IDLE;
      end
      if (wr && wb_adr_i == ADR_KEY && wb_sel_i[0]) // RULE10
      begin
         s_nxt.kcnt = KEY_WINDOW_CYC;
         if (dat[7:0] == KEY_FIRST)
            s_nxt.key = KEY_HALF;
         else if (s_r.key == KEY_HALF && dat[7:0] == KEY_SECOND)
            s_nxt.key = KEY_OPEN;
         else
            s_nxt.key = KEY_IDLE;
      end

      // Register writes
      ci.wr_hi = wr && wb_adr_i == ADR_VAL && wb_sel_i[1] && unlock; // RULE9
      ci.wr_lo = wr && wb_adr_i == ADR_VAL && wb_sel_i[0] && unlock; // RULE9
      ci.ptr = ptr;
      ci.wdata = dat;
      ci.tick = tick;
      if (wr && wb_adr_i == ADR_CFG)
      begin
         if (wb_sel_i[0])
            s_nxt.cfg[7:0] = dat[7:0];
         if (wb_sel_i[1])
         begin
            if (unlock) // RULE11
               s_nxt.cfg[ON_BIT] = dat[ON_BIT];
            if (!dat[UNLOCK_BIT])
               s_nxt.cfg[UNLOCK_BIT] = 1'b0;
            else if (s_r.key == KEY_OPEN) // RULE10
               s_nxt.cfg[UNLOCK_BIT] = 1'b1;
            s_nxt.cfg[OE_BIT] = dat[OE_BIT]; // RULE15
            s_nxt.cfg[PTR_LSB+1:PTR_LSB] = dat[PTR_LSB+1:PTR_LSB];
         end
      end
      if ((rd || ci.wr_hi) && wb_adr_i == ADR_VAL && ptr != 2'h0) // RULE4 RULE5
         s_nxt.cfg[PTR_LSB+1:PTR_LSB] = ptr - 2'h1;
      if (ci.wr_lo && ptr == 2'h0) // RULE14
      begin
         s_nxt.presc = 18'sd0;
         s_nxt.half = 1'b0;
      end
      if (wr && wb_adr_i == ADR_ACFG)
      begin
         if (wb_sel_i[1])
            s_nxt.acfg[15:8] = dat[15:8];
         if (wb_sel_i[0])
            s_nxt.acfg[7:0] = dat[7:0];
      end
      if (wr && wb_adr_i == ADR_AVAL) // RULE6
      begin
         case (aptr)
            2'h0: s_nxt.a_ms = {wb_sel_i[1] ? dat[15:8] : s_r.a_ms[15:8],
                                wb_sel_i[0] ? dat[7:0] : s_r.a_ms[7:0]};
            2'h1: s_nxt.a_wh = {wb_sel_i[1] ? dat[15:8] : s_r.a_wh[15:8],
                                wb_sel_i[0] ? dat[7:0] : s_r.a_wh[7:0]};
            2'h2: s_nxt.a_md = {wb_sel_i[1] ? dat[15:8] : s_r.a_md[15:8],
                                wb_sel_i[0] ? dat[7:0] : s_r.a_md[7:0]};
            default: s_nxt.a_ms = s_r.a_ms;
         endcase
      end
      if ((rd || (wr && wb_sel_i[1])) && wb_adr_i == ADR_AVAL &&
          aptr != 2'h0) // RULE7 RULE8
         s_nxt.acfg[PTR_LSB+1:PTR_LSB] = aptr - 2'h1;
      if (wr && wb_adr_i == ADR_PWC && wb_sel_i[1]) // RULE1
         s_nxt.src = dat[SRC_LSB+1:SRC_LSB];

      // Read data
      s_nxt.rdata = 16'h0000;
      if (rd)
      begin
         case (wb_adr_i)
            ADR_CFG: s_nxt.rdata = {s_r.cfg[15], 1'b0, s_r.cfg[13],
                                    ripple, s_r.half, s_r.cfg[10:0]};
            ADR_VAL: // RULE3
               case (ptr)
                  2'h0: s_nxt.rdata = {t.min, t.sec};
                  2'h1: s_nxt.rdata = {t.wday, t.hr};
                  2'h2: s_nxt.rdata = {t.mon, t.day};
                  default: s_nxt.rdata = {8'h00, t.yr};
               endcase
            ADR_ACFG: s_nxt.rdata = s_r.acfg;
            ADR_AVAL: // RULE6
               case (aptr)
                  2'h0: s_nxt.rdata = s_r.a_ms;
                  2'h1: s_nxt.rdata = s_r.a_wh;
                  2'h2: s_nxt.rdata = s_r.a_md;
                  default: s_nxt.rdata = 16'h0000;
               endcase
            ADR_PWC: s_nxt.rdata = {4'h0, s_r.src, 10'h000};
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
      s_nxt.out = s_r.cfg[OE_BIT] & s_r.cfg[ON_BIT] & ~s_r.half; // RULE15

      // Other resets leave the config register alone
      if (sys_rst) // RULE16
      begin
         s_nxt.acfg = ACFG_RST;
         s_nxt.key = KEY_IDLE;
         s_nxt.kcnt = 3'h0;
         s_nxt.alarm = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.cfg <= CFG_RST; // RULE12 RULE16
         s_r.acfg <= ACFG_RST;
         s_r.src <= SRC_RST;
         s_r.key <= KEY_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = {16'h0000, s_r.rdata};
   assign unit_out = s_r.out;
   assign alarm_pulse = s_r.alarm;

   // =======================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence val_access;
      acc && wb_adr_i == ADR_VAL;
   endsequence
   sequence aval_access;
      acc && wb_adr_i == ADR_AVAL;
   endsequence

   a_ptr_write_dec: assert property ( // RULE4
      (val_access ##0 ci.wr_hi && ptr != 2'h0)
      |=> s_r.cfg[9:8] == $past(ptr) - 2'h1)
      else $error("time pointer not decremented on write");
   a_ptr_stays_zero: assert property ( // RULE4
      (val_access ##0 ptr == 2'h0) |=> s_r.cfg[9:8] == 2'h0)
      else $error("time pointer left zero");
   a_ptr_read_dec: assert property ( // RULE5
      (val_access ##0 !wb_we_i && ptr != 2'h0)
      |=> s_r.cfg[9:8] == $past(ptr) - 2'h1)
      else $error("time pointer not decremented on read");
   a_locked_write: assert property ( // RULE9
      (val_access ##0 wb_we_i && !s_r.cfg[13]) |-> !ci.wr_hi && !ci.wr_lo)
      else $error("time write passed while locked");
   a_alarm_ptr_write: assert property ( // RULE7
      (aval_access ##0 wb_we_i && wb_sel_i[1] && aptr != 2'h0 && !sys_rst)
      |=> s_r.acfg[9:8] == $past(aptr) - 2'h1)
      else $error("alarm pointer not decremented on write");
   a_alarm_ptr_read: assert property ( // RULE8
      (aval_access ##0 !wb_we_i && aptr != 2'h0 && !sys_rst)
      |=> s_r.acfg[9:8] == $past(aptr) - 2'h1)
      else $error("alarm pointer not decremented on read");
   a_unlock_key: assert property ( // RULE10
      $rose(s_r.cfg[13]) |-> $past(s_r.key) == KEY_OPEN)
      else $error("unlock set without key sequence");
   a_on_guarded: assert property ( // RULE11
      $changed(s_r.cfg[15]) |-> $past(s_r.cfg[13]))
      else $error("module on changed while locked");
   a_half_clear: assert property ( // RULE14
      (val_access ##0 ci.wr_lo && ptr == 2'h0) |=> !s_r.half ##1 1'b1)
      else $error("half second not cleared");
   a_ripple_warn: assert property ( // RULE13
      tick |-> ripple)
      else $error("tick without ripple warning");
   a_alarm_stop: assert property ( // RULE19
      (s_r.acfg[15] && hit && s_r.acfg[7:0] == 8'h00 && !s_r.acfg[14] &&
       !(wr && wb_adr_i == ADR_ACFG) && !sys_rst)
      |=> !s_r.acfg[15] && alarm_pulse)
      else $error("alarm not disarmed after last event");
endmodule // calendar_clock_unit

/* File: src/calclk_pkg.sv */
// Constants, types and helpers shared by the calendar clock unit.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone slave port.
package calclk_pkg;

   // =======================================================
   // Register byte offsets
   localparam logic [7:0] ADR_CFG = 8'h00;
   localparam logic [7:0] ADR_VAL = 8'h04;
   localparam logic [7:0] ADR_ACFG = 8'h08;
   localparam logic [7:0] ADR_AVAL = 8'h0c;
   localparam logic [7:0] ADR_KEY = 8'h10;
   localparam logic [7:0] ADR_PWC = 8'h14;

   // =======================================================
   // Field positions and reset values
   localparam int ON_BIT = 15;
   localparam int UNLOCK_BIT = 13;
   localparam int RIPPLE_BIT = 12;
   localparam int HALF_BIT = 11;
   localparam int OE_BIT = 10;
   localparam int PTR_LSB = 8;
   localparam int ALM_EN_BIT = 15;
   localparam int CHIME_BIT = 14;
   localparam int MASK_LSB = 10;
   localparam int SRC_LSB = 10;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] ACFG_RST = 16'h0000;
   localparam logic [1:0] SRC_RST = 2'h0;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // =======================================================
   // Timing
   localparam int CLK_NS = 50;
   localparam int KEY_WINDOW_NS = 200;
   localparam logic [2:0] KEY_WINDOW_CYC = 3'(KEY_WINDOW_NS / CLK_NS);
   localparam int SECONDARY_CRYSTAL_OSC_HZ = 32768;
   localparam int LOW_POWER_RC_OSC_HZ = 31250;
   localparam int LINE50_HZ = 50;
   localparam int LINE60_HZ = 60;
   localparam logic [3:0] TRIM_SECONDS = 4'hf;
   localparam logic signed [17:0] RIPPLE_PULSES = 18'sd1;

   typedef struct packed {
      logic [7:0] yr;
      logic [7:0] mon;
      logic [7:0] day;
      logic [7:0] wday;
      logic [7:0] hr;
      logic [7:0] min;
      logic [7:0] sec;
   } time_type;

   localparam time_type TIME_RST = '{8'h00, 8'h01, 8'h01, 8'h00,
                                     8'h00, 8'h00, 8'h00};

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
   endfunction

   function automatic logic [7:0] days_in_month(input logic [7:0] mon,
                                                input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      case (mon)
         8'h02: days_in_month = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
         default: days_in_month = 8'h31;
      endcase
   endfunction

endpackage

/* File: src/cal_if.sv */
// Link between the register front end and the calendar counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cal_if;
   import calclk_pkg::*;
   logic tick;
   logic wr_hi;
   logic wr_lo;
   logic [1:0] ptr;
   logic [15:0] wdata;
   time_type now;
   modport ctl (output tick, wr_hi, wr_lo, ptr, wdata, input now);
   modport cnt (input tick, wr_hi, wr_lo, ptr, wdata, output now);
endinterface

/* File: src/pulse_sync.sv */
// Two-stage synchroniser with rising edge detect for a timebase pin.
// Assumes the pin toggles far slower than clk.
`timescale 1ns/1ps
module pulse_sync
(
   input wire logic clk,   // System clock
   input wire logic rst_n, // Synchronised reset
   input wire logic din,   // Asynchronous pin
   output logic rise       // One-cycle pulse per rising edge
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_type;

   sync_type s_r;
   sync_type s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.s1 = din;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      rise = s_r.s2 & ~s_r.s3;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule // pulse_sync

/* File: src/calendar_count.sv */
// BCD time of day and date counter with pointer-selected byte writes.
// Assumes one tick per second and write strobes already qualified.
`timescale 1ns/1ps
module calendar_count
   import calclk_pkg::*;
(
   input wire logic clk,   // System clock
   input wire logic rst_n, // Synchronised power-on reset
   cal_if.cnt ci           // Tick, writes and current time
);
   time_type s_r;
   time_type s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (ci.tick) // RULE21
      begin
         if (s_r.sec != 8'h59)
            s_nxt.sec = bcd_inc(s_r.sec);
         else
         begin
            s_nxt.sec = 8'h00;
            if (s_r.min != 8'h59)
               s_nxt.min = bcd_inc(s_r.min);
            else
            begin
               s_nxt.min = 8'h00;
               if (s_r.hr != 8'h23) // RULE18
                  s_nxt.hr = bcd_inc(s_r.hr);
               else
               begin
                  s_nxt.hr = 8'h00;
                  s_nxt.wday = (s_r.wday == 8'h06) ? 8'h00
                                                   : bcd_inc(s_r.wday);
                  if (s_r.day != days_in_month(s_r.mon, s_r.yr)) // RULE18
                     s_nxt.day = bcd_inc(s_r.day);
                  else
                  begin
                     s_nxt.day = 8'h01;
                     if (s_r.mon != 8'h12)
                        s_nxt.mon = bcd_inc(s_r.mon);
                     else
                     begin
                        s_nxt.mon = 8'h01;
                        s_nxt.yr = (s_r.yr == 8'h99) ? 8'h00
                                                     : bcd_inc(s_r.yr);
                     end
                  end
               end
            end
         end
      end
      // Software writes win over the tick
      if (ci.wr_hi) // RULE3
      begin
         case (ci.ptr)
            2'h0: s_nxt.min = {1'b0, ci.wdata[14:8]};
            2'h1: s_nxt.wday = {5'h0, ci.wdata[10:8]};
            2'h2: s_nxt.mon = {3'h0, ci.wdata[12:8]};
            default: s_nxt.yr = s_r.yr;
         endcase
      end
      if (ci.wr_lo) // RULE3
      begin
         case (ci.ptr)
            2'h0: s_nxt.sec = {1'b0, ci.wdata[6:0]};
            2'h1: s_nxt.hr = {2'h0, ci.wdata[5:0]};
            2'h2: s_nxt.day = {2'h0, ci.wdata[5:0]};
            default: s_nxt.yr = ci.wdata[7:0];
         endcase
      end
      ci.now = s_r;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= TIME_RST;
      else
         s_r <= s_nxt;
   end
endmodule // calendar_count

/* File: bench/calendar_clock_unit_tb_top.sv */
// Self-checking bench for the calendar clock unit register front end.
// Assumes the design package is compiled first; only the line pin toggles.
`timescale 1ns/1ps
module calendar_clock_unit_tb_top;
   import calclk_pkg::*;
   logic clk, resetn, sys_rst, cyc, stb, we, ack, uout, apulse, line;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, rdat, q, seed;
   int errors, checks_done, cycles, alarms;

   calendar_clock_unit dut_u (.clk(clk), .resetn(resetn),
      .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .secondary_crystal_osc_in(1'b0), .low_power_rc_osc_in(1'b0), .line_in(line),
      .unit_out(uout), .alarm_pulse(apulse));

   // =======================================================
   // Clock, timeout and helpers
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (apulse === 1'b1)
         alarms++;
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_sim();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic cycle: hold until ack is sampled high, then release
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      dat <= {16'h0000, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20)
      begin
         errors++;
         $display("mismatch ack expected 1 seen %b", ack);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                      input string nm);
      bus(1'b0, a, 16'h0000);
      chk(nm, e, q[15:0]);
   endtask

   // Line timebase pulses, then let the synchroniser drain
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk);
         line <= 1'b1;
         @(posedge clk);
         line <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask

   // =======================================================
   // Main sequence
   initial
   begin
      logic [15:0] m_cfg;
      {resetn, sys_rst, cyc, stb, we, adr, sel, dat, line} = '0;
      seed = 32'hd4ef;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(ADR_CFG, CFG_RST, "cfg reset");
      rdc(ADR_ACFG, ACFG_RST, "acfg reset");
      rdc(8'h18, 16'h0000, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         m_cfg = 16'h0700 | {8'h00, seed[7:0]};
         bus(1'b1, ADR_CFG, 16'hbf00 | {8'h00, seed[7:0]});
         rdc(ADR_CFG, m_cfg, "cfg locked");
         chk("unit_out", 16'h0000, {15'h0000, uout});
      end
      $display("test lock bits done");
      bus(1'b1, ADR_CFG, 16'h0300);
      bus(1'b1, ADR_VAL, 16'h0099);
      rdc(ADR_CFG, 16'h0300, "ptr locked");
      rdc(ADR_VAL, 16'h0000, "year locked");
      rdc(ADR_CFG, 16'h0200, "ptr after read");
      $display("test locked window done");
      bus(1'b1, ADR_KEY, {8'h00, KEY_FIRST});
      bus(1'b1, ADR_KEY, {8'h00, KEY_SECOND});
      bus(1'b1, ADR_CFG, 16'h2300);
      rdc(ADR_CFG, 16'h2300, "unlock");
      bus(1'b1, ADR_VAL, 16'h0025);
      rdc(ADR_CFG, 16'h2200, "ptr after write");
      bus(1'b1, ADR_CFG, 16'ha300);
      rdc(ADR_CFG, 16'ha300, "on bit");
      rdc(ADR_VAL, 16'h0025, "year");
      bus(1'b1, ADR_CFG, 16'h2000);
      rdc(ADR_VAL, 16'h0000, "min sec");
      rdc(ADR_CFG, 16'h2000, "ptr stays");
      $display("test unlocked window done");
      bus(1'b1, ADR_ACFG, 16'h0200);
      rdc(ADR_ACFG, 16'h0200, "acfg");
      bus(1'b1, ADR_AVAL, 16'h1200);
      rdc(ADR_ACFG, 16'h0100, "aptr write");
      rdc(ADR_AVAL, 16'h0000, "alarm wd hr");
      rdc(ADR_ACFG, 16'h0000, "aptr read");
      bus(1'b1, ADR_AVAL, 16'h3400);
      rdc(ADR_ACFG, 16'h0000, "aptr floor");
      rdc(ADR_AVAL, 16'h3400, "alarm min sec");
      bus(1'b1, ADR_ACFG, 16'h0300);
      rdc(ADR_AVAL, 16'h0000, "alarm none");
      rdc(ADR_ACFG, 16'h0200, "aptr none");
      $display("test alarm window done");
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rdc(ADR_CFG, 16'h2000, "cfg kept");
      rdc(ADR_ACFG, 16'h0000, "acfg cleared");
      bus(1'b1, ADR_PWC, 16'h0c00);
      rdc(ADR_PWC, 16'h0c00, "source");
      $display("test other reset done");
      bus(1'b1, ADR_CFG, 16'ha400);
      rdc(ADR_CFG, 16'ha400, "on out");
      chk("unit_out on", 16'h0001, {15'h0000, uout});
      bus(1'b1, ADR_VAL, 16'h5958);
      pulses(90);
      rdc(ADR_CFG, 16'hac00, "half second");
      chk("unit_out half", 16'h0000, {15'h0000, uout});
      pulses(30);
      rdc(ADR_VAL, 16'h0000, "rollover");
      bus(1'b1, ADR_CFG, 16'ha500);
      rdc(ADR_VAL, 16'h0001, "hour carry");
      pulses(59);
      rdc(ADR_CFG, 16'hbc00, "ripple");
      bus(1'b1, ADR_ACFG, 16'h8400);
      pulses(1);
      rdc(ADR_ACFG, 16'h0400, "alarm disarm");
      chk("alarm_pulse", 16'h0001, alarms[15:0]);
      $display("test timebase done");
      end_sim();
   end
endmodule // calendar_clock_unit_tb_top
